/* rtl/irc_codec.sv */
// How it works
// R1 - Enable bit set routes UART traffic through the codec; clear bypasses it.
// R2 - Half-duplex: transmit and receive never run at the same time.
// R3 - Software enables the UART before using the codec.
// R4 - Bit rate is system clock over sixteen times the baud divisor.
// R5 - Standard rates 9600 to 115.2 kbaud supported; faster ones allowed.
// R6 - Every bit spans exactly 16 baud clocks.
// R7 - Encoder builds its output from UART serial output and baud clock.
// R8 - A one keeps the infrared output low the whole bit.
// R9 - A zero gives 7 low, 3 high, then 6 low clocks.
// R10 - When enabled the UART output stays inside; encoder drives the pin.
// R11 - When enabled the receive pin feeds the decoder, which drives UART input.
// R12 - Decoder times the recovered stream with the baud clock.
// R13 - Decoder keeps a local 0 to 15 baud clock counter.
// R14 - Recovered input lags the incoming pulses by 8 baud clocks.
// R15 - A falling edge on the incoming stream resets the counter.
// R16 - At count 8 the recovered input takes the decoded bit.
// R17 - Window opens at 12 and closes at 8, 24 clocks after a pulse.
// R18 - System clock of at least 1.0 MHz to catch 1.4 us pulses.
// R19 - Pulse in window decodes as 0; no pulse, idle line, as 1.
// R20 - Pulses outside the window are ignored entirely.
`timescale 1ns/1ps
`include "irc_defines.svh"
module irc_codec #(
  parameter int unsigned DIV_W      = `IRC_DIV_W,
  parameter int unsigned FIFO_DEPTH = `IRC_FIFO_DEPTH
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst,
  input  wire logic             i_infrared_codec_enable,
  input  wire logic [DIV_W-1:0] i_baud_div,
  input  wire logic             i_uart_txd,
  input  wire logic             i_uart_tx_valid,
  output logic                  o_uart_tx_ready,
  output logic                  o_uart_rxd,
  output logic                  o_txd_pin,
  input  wire logic             i_rxd_pin,
  output logic                  o_tx_busy,
  output logic                  o_rx_active
);

  // Baud divider
  // Enables are one system clock wide; nothing here runs on a second clock
  logic [DIV_W-1:0] div_cnt_r;
  logic [DIV_W-1:0] div_cnt_nxt;
  logic             baud_tick;

  // Encoder state
  irc_pkg::irc_tx_state_t tx_state_r;
  irc_pkg::irc_tx_state_t tx_state_nxt;
  logic [`IRC_CNT_W-1:0]  tx_cnt_r;
  logic [`IRC_CNT_W-1:0]  tx_cnt_nxt;
  logic                   tx_bit_r;
  logic                   tx_bit_nxt;
  logic                   txd_r;
  logic                   txd_nxt;
  logic                   tx_pop;
  logic                   tx_pulse;

  // Decoder state
  irc_pkg::irc_rx_flags_t rx_r;
  irc_pkg::irc_rx_flags_t rx_nxt;
  logic [`IRC_CNT_W-1:0]  rx_cnt_r;
  logic [`IRC_CNT_W-1:0]  rx_cnt_nxt;
  logic                   rx_prev_r;
  logic                   rx_prev_nxt;
  logic                   rxd_r;
  logic                   rxd_nxt;
  logic                   rx_fall;
  logic                   rx_win_open;
  logic                   rx_accept;

  // Buffer between UART line and encoder
  // Read data is registered, hence the load state between pop and send
  logic                   fifo_wr_valid;
  logic                   fifo_wr_ready;
  logic                   fifo_rd_valid;
  irc_pkg::irc_tx_word_t  fifo_wr_data;
  irc_pkg::irc_tx_word_t  fifo_rd_data;

  // Both bit counters wrap after 16 baud clocks
  // Wrap comes free from the four-bit width, no compare needed
  function automatic logic [`IRC_CNT_W-1:0] cnt_inc(input logic [`IRC_CNT_W-1:0] c);
    cnt_inc = c + 1'b1;
  endfunction

  // Divider turns the system clock into one-cycle baud enables.
  // A divisor of zero is taken as one rather than stalling.
  // Limitation: a divisor change mid-bit bends only the bit in flight,
  // so change it while the link is quiet.
  // R4 divisor rate
  // R5 full divisor range
  always_comb begin
    baud_tick = (i_baud_div == '0) || (div_cnt_r >= i_baud_div - 1'b1);
    if (!i_infrared_codec_enable || baud_tick) begin
      div_cnt_nxt = '0;
    end else begin
      div_cnt_nxt = div_cnt_r + 1'b1;
    end
  end

  // Divider count register
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      div_cnt_r <= '0;
    end else begin
      div_cnt_r <= div_cnt_nxt;
    end
  end

  // UART bits enter the buffer only while the codec owns the line
  // Words queued before a bypass spell are kept and go out on the next
  // enable; drain them first for a clean start.
  // R10 UART output internal
  always_comb begin
    fifo_wr_valid         = i_uart_tx_valid & i_infrared_codec_enable;
    fifo_wr_data.data_bit = i_uart_txd;
    o_uart_tx_ready       = fifo_wr_ready & i_infrared_codec_enable;
  end

  // Eight words absorb a burst of UART bits while the encoder
  // spends sixteen baud clocks on each one
  irc_fifo #(
    .WIDTH ($bits(irc_pkg::irc_tx_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .i_clk_sys  (i_clk_sys),
    .i_rst      (i_rst),
    .i_wr_valid (fifo_wr_valid),
    .o_wr_ready (fifo_wr_ready),
    .i_wr_data  (fifo_wr_data),
    .o_rd_valid (fifo_rd_valid),
    .i_rd_ready (tx_pop),
    .o_rd_data  (fifo_rd_data)
  );

  // Encoder takes a new bit only at a bit boundary. A new frame does not
  // start while the decoder is tracking pulses, so the link stays half-duplex.
  // A pulse taken in the very cycle of a start would make both sides busy,
  // so that cycle holds the encoder back as well.
  // R2 no start during receive
  // R6 sixteen clock bits
  always_comb begin
    tx_pop = i_infrared_codec_enable & baud_tick & fifo_rd_valid
           & (tx_cnt_r == `IRC_CNT_LAST)
           & ((tx_state_r == irc_pkg::IRC_TX_SEND)
              | ((tx_state_r == irc_pkg::IRC_TX_IDLE) & ~rx_r.active & ~rx_accept));
  end

  // Encoder sequencing and bit counter
  // Disable clears the sequencer so a re-enable starts on a clean bit.
  // The counter free-runs while enabled, so a first bit waits at most
  // sixteen baud clocks for its boundary.
  // R7 UART bit and baud clock
  always_comb begin
    tx_state_nxt = tx_state_r;
    tx_bit_nxt   = tx_bit_r;
    tx_cnt_nxt   = tx_cnt_r;
    if (!i_infrared_codec_enable) begin
      tx_state_nxt = irc_pkg::IRC_TX_IDLE;
      tx_bit_nxt   = 1'b1;
      tx_cnt_nxt   = '0;
    end else begin
      if (baud_tick) begin
        tx_cnt_nxt = cnt_inc(tx_cnt_r);
      end
      unique case (tx_state_r)
        irc_pkg::IRC_TX_IDLE: begin
          if (tx_pop) begin
            tx_state_nxt = irc_pkg::IRC_TX_LOAD;
          end
        end
        irc_pkg::IRC_TX_LOAD: begin
          tx_bit_nxt   = fifo_rd_data.data_bit;
          tx_state_nxt = irc_pkg::IRC_TX_SEND;
        end
        irc_pkg::IRC_TX_SEND: begin
          if (tx_pop) begin
            tx_state_nxt = irc_pkg::IRC_TX_LOAD;
          end else if (baud_tick && tx_cnt_r == `IRC_CNT_LAST) begin
            tx_state_nxt = irc_pkg::IRC_TX_IDLE;
          end
        end
        default: begin
          tx_state_nxt = irc_pkg::IRC_TX_IDLE;
        end
      endcase
    end
  end

  // Pulse shape: a one stays low, a zero is high for counts 7 to 9.
  // Load lands at count 0 or 1, well before the pulse, so shape is kept.
  // The pin register moves the pulse one system clock later, to counts 8 to 10 at divisor 1; widths and
  // spacing within the bit are unchanged.
  // R8 one stays low
  // R9 seven three six
  always_comb begin
    tx_pulse = (tx_state_r == irc_pkg::IRC_TX_SEND) & ~tx_bit_r
             & (tx_cnt_r >= 4'(`IRC_TX_LOW_HEAD))
             & (tx_cnt_r < 4'(`IRC_TX_LOW_HEAD + `IRC_TX_PULSE_LEN));
  end

  // Pin mux on the transmit side
  // Bypass also goes through the pin register: one clock of latency
  // traded for a glitch-free pin when the enable toggles.
  // R1 codec or bypass
  // R10 encoder drives pin
  always_comb begin
    txd_nxt = i_infrared_codec_enable ? tx_pulse : i_uart_txd;
  end

  // Encoder registers; the pin idles low so the emitter stays dark
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      tx_state_r <= irc_pkg::IRC_TX_IDLE;
      tx_cnt_r   <= '0;
      tx_bit_r   <= 1'b1;
      txd_r      <= 1'b0;
    end else begin
      tx_state_r <= tx_state_nxt;
      tx_cnt_r   <= tx_cnt_nxt;
      tx_bit_r   <= tx_bit_nxt;
      txd_r      <= txd_nxt;
    end
  end

  // Falling edge on the incoming stream. Pulses seen while the encoder
  // is busy are our own echo or a collision and are dropped.
  // Limitation: a pulse shorter than one system clock can be missed.
  // The window check keeps stray reflections from restarting the count.
  // R2 ignore during transmit
  // R20 closed window ignored
  always_comb begin
    rx_prev_nxt = i_rxd_pin;
    rx_fall     = rx_prev_r & ~i_rxd_pin;
    rx_win_open = ~rx_r.active | rx_r.win;
    rx_accept   = i_infrared_codec_enable & rx_fall & rx_win_open
                & (tx_state_r == irc_pkg::IRC_TX_IDLE);
  end

  // Decoder: counter paced by baud clock, restarted by each accepted pulse
  // A pulse missing from the window ends tracking at the next count 8,
  // and the recovered line goes back to idle high.
  // Enable low clears tracking so stale counts never survive a mode change.
  // R12 baud clock timing
  // R13 local sixteen count
  always_comb begin
    rx_nxt     = rx_r;
    rx_cnt_nxt = rx_cnt_r;
    rxd_nxt    = rxd_r;
    if (!i_infrared_codec_enable) begin
      rx_nxt     = '{active: 1'b0, win: 1'b0, pend: 1'b1};
      rx_cnt_nxt = '0;
      // R1 bypass receive
      rxd_nxt    = i_rxd_pin;
    end else if (rx_accept) begin
      // R15 edge resets counter
      rx_cnt_nxt = '0;
      rx_nxt     = '{active: 1'b1, win: 1'b0, pend: 1'b0};
    end else if (baud_tick) begin
      rx_cnt_nxt = cnt_inc(rx_cnt_r);
      // R17 window opens at 12
      if (cnt_inc(rx_cnt_r) == `IRC_RX_WIN_OPEN) begin
        rx_nxt.win = 1'b1;
      end
      // R14 eight clock lag
      // R16 update at 8
      if (cnt_inc(rx_cnt_r) == `IRC_RX_UPDATE) begin
        // R19 pulse zero else one
        rxd_nxt     = rx_r.pend;
        rx_nxt.pend = 1'b1;
        // R17 window closes at 8
        if (rx_r.win) begin
          rx_nxt.active = 1'b0;
        end
      end
    end
  end

  // Decoder registers; the recovered line idles high
  // Edge history resets high, the idle level of the pin, so no false
  // edge follows reset.
  // R11 decoder drives UART input
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      rx_r      <= '{active: 1'b0, win: 1'b0, pend: 1'b1};
      rx_cnt_r  <= '0;
      rx_prev_r <= 1'b1;
      rxd_r     <= 1'b1;
    end else begin
      rx_r      <= rx_nxt;
      rx_cnt_r  <= rx_cnt_nxt;
      rx_prev_r <= rx_prev_nxt;
      rxd_r     <= rxd_nxt;
    end
  end

  // Outputs
  // Busy covers load and send; active covers the whole pulse train,
  // which is what the half-duplex guard watches.
  assign o_txd_pin   = txd_r;
  assign o_uart_rxd  = rxd_r;
  assign o_tx_busy   = (tx_state_r != irc_pkg::IRC_TX_IDLE);
  assign o_rx_active = rx_r.active;

endmodule // irc_codec

/* rtl/irc_defines.svh */
`ifndef IRC_DEFINES_SVH
`define IRC_DEFINES_SVH

// Clocks per encoded bit and the counter width that holds them
`define IRC_BIT_CLKS     16
`define IRC_CNT_W        4
`define IRC_CNT_LAST     4'hF
// Transmit pulse for a zero: 7 low, 3 high, 6 low
`define IRC_TX_LOW_HEAD  7
`define IRC_TX_PULSE_LEN 3
`define IRC_TX_LOW_TAIL  6
// Receive counter points
`define IRC_RX_UPDATE    4'h8
`define IRC_RX_WIN_OPEN  4'hC
`define IRC_RX_WIN_SPAN  24
// Standard baud range and the lowest system clock in Hz
`define IRC_STD_BAUD_MIN 9600
`define IRC_STD_BAUD_MAX 115200
`define IRC_MIN_SYS_HZ   1000000
// Buffering and divisor width
`define IRC_FIFO_DEPTH   8
`define IRC_DIV_W        16

`endif

/* rtl/irc_fifo.sv */
`timescale 1ns/1ps
module irc_fifo #(
  parameter int unsigned WIDTH = 1,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst,
  input  wire logic             i_wr_valid,
  output logic                  o_wr_ready,
  input  wire logic [WIDTH-1:0] i_wr_data,
  output logic                  o_rd_valid,
  input  wire logic             i_rd_ready,
  output logic      [WIDTH-1:0] o_rd_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    wr_ptr_nxt;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW-1:0]    rd_ptr_nxt;
  logic [AW:0]      count_r;
  logic [AW:0]      count_nxt;
  logic [WIDTH-1:0] data_r;
  logic             push;
  logic             pop;

  // Pointer wrap shared by both sides
  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // Honest full and empty from the occupancy count
  always_comb begin
    o_wr_ready = (count_r != (AW+1)'(DEPTH));
    o_rd_valid = (count_r != '0);
    push       = i_wr_valid & o_wr_ready;
    pop        = i_rd_ready & o_rd_valid;
    wr_ptr_nxt = push ? ptr_inc(wr_ptr_r) : wr_ptr_r;
    rd_ptr_nxt = pop ? ptr_inc(rd_ptr_r) : rd_ptr_r;
    count_nxt  = count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  // Read data leaves through a register, one cycle after the pop
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
      data_r   <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r  <= count_nxt;
      if (pop) begin
        data_r <= mem_r[rd_ptr_r];
      end
    end
  end

  // Storage needs no reset
  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem_r[wr_ptr_r] <= i_wr_data;
    end
  end

  assign o_rd_data = data_r;
endmodule // irc_fifo

/* rtl/irc_pkg.sv */
package irc_pkg;

  // Encoder sequencing
  typedef enum logic [1:0] {
    IRC_TX_IDLE = 2'b00,
    IRC_TX_LOAD = 2'b01,
    IRC_TX_SEND = 2'b10
  } irc_tx_state_t;

  // One buffered UART line bit
  typedef struct packed {
    logic data_bit;
  } irc_tx_word_t;

  // Decoder tracking flags
  typedef struct packed {
    logic active;
    logic win;
    logic pend;
  } irc_rx_flags_t;

endpackage

/* testbench/irc_codec_checker.sv */
`timescale 1ns/1ps
module irc_codec_checker #(
  parameter int unsigned DIV_W      = 16,
  parameter int unsigned FIFO_DEPTH = 8
) (
  input wire logic             i_clk_sys,
  input wire logic             i_rst,
  input wire logic             i_infrared_codec_enable,
  input wire logic [DIV_W-1:0] i_baud_div,
  input wire logic             i_uart_txd,
  input wire logic             i_uart_tx_valid,
  input wire logic             o_uart_tx_ready,
  input wire logic             o_uart_rxd,
  input wire logic             o_txd_pin,
  input wire logic             i_rxd_pin,
  input wire logic             o_tx_busy,
  input wire logic             o_rx_active
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // Timing figures below assume one baud enable per clock
  logic en_q;
  assign en_q = i_infrared_codec_enable && (i_baud_div == 16'h0001);
  // Accepted falling edge on the receive pin
  sequence rx_edge_s;
    en_q && $past(en_q) && !$past(i_rst) && !o_tx_busy && !o_rx_active
    && $past(i_rxd_pin) && !i_rxd_pin;
  endsequence
  sequence tx_gap_s;
    !o_txd_pin[*7] ##1 !o_txd_pin[*6];
  endsequence
  bypass_tx_a: assert property (
    !i_infrared_codec_enable && !$past(i_infrared_codec_enable) && !$past(i_rst)
    |-> o_txd_pin == $past(i_uart_txd)) else $error("bypass tx path wrong");
  bypass_rx_a: assert property (
    !i_infrared_codec_enable && !$past(i_infrared_codec_enable) && !$past(i_rst)
    |-> o_uart_rxd == $past(i_rxd_pin)) else $error("bypass rx path wrong");
  ready_gate_a: assert property (
    !i_infrared_codec_enable |-> !o_uart_tx_ready) else $error("ready while bypassed");
  half_duplex_a: assert property (
    o_tx_busy |-> !o_rx_active) else $error("tx and rx together");
  pulse_width_a: assert property (
    en_q && $rose(o_txd_pin) |-> o_txd_pin[*3] ##1 !o_txd_pin) else $error("pulse width");
  pulse_gap_a: assert property (
    en_q && $fell(o_txd_pin) |-> tx_gap_s) else $error("low gap too short");
  rx_lag_a: assert property (
    rx_edge_s |-> o_uart_rxd[*8] ##[1:3] !o_uart_rxd) else $error("rx lag wrong");
  rx_start_a: assert property (
    rx_edge_s |=> o_rx_active) else $error("rx not tracking");
  rx_release_a: assert property (
    en_q && $fell(o_rx_active) |-> ##[0:1] o_uart_rxd) else $error("idle not one");
endmodule // irc_codec_checker

bind irc_codec irc_codec_checker #(.DIV_W(DIV_W), .FIFO_DEPTH(FIFO_DEPTH)) irc_codec_checker_inst (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_infrared_codec_enable(i_infrared_codec_enable),
  .i_baud_div(i_baud_div), .i_uart_txd(i_uart_txd), .i_uart_tx_valid(i_uart_tx_valid),
  .o_uart_tx_ready(o_uart_tx_ready), .o_uart_rxd(o_uart_rxd), .o_txd_pin(o_txd_pin),
  .i_rxd_pin(i_rxd_pin), .o_tx_busy(o_tx_busy), .o_rx_active(o_rx_active));

/* testbench/irc_xcvr_model.sv */
`timescale 1ns/1ps
module irc_xcvr_model #(
  parameter int unsigned PULSE_CLKS = 3
) (
  input  wire logic i_clk_sys,
  input  wire logic i_fire,
  output logic      o_rxd_pin
);
  int unsigned cnt_r = 0;
  // pulse held long enough to catch
  always_ff @(posedge i_clk_sys) begin
    if (i_fire) cnt_r <= PULSE_CLKS;
    else if (cnt_r != 0) cnt_r <= cnt_r - 1;
  end
  // Pull-up keeps the line high between pulses
  assign o_rxd_pin = (cnt_r == 0);
endmodule // irc_xcvr_model

/* testbench/tb_infrared_pulse_codec.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  $display("mismatch %s exp %0h got %0h", nm, e, g); num_errors++; end end
module tb_infrared_pulse_codec;
  logic clk, rst, en, txd, tx_valid, fire, tx_ready, rxd, txd_pin, rxd_pin, tx_busy, rx_act;
  logic [15:0] baud_div;
  logic txd_q = 1'b0;
  int   num_errors = 0, samples_checked = 0, n_rise = 0, cyc = 0, first_r = 0, last_r = 0;
  irc_codec irc_codec_inst (.i_clk_sys(clk), .i_rst(rst), .i_infrared_codec_enable(en),
    .i_baud_div(baud_div), .i_uart_txd(txd), .i_uart_tx_valid(tx_valid),
    .o_uart_tx_ready(tx_ready), .o_uart_rxd(rxd), .o_txd_pin(txd_pin), .i_rxd_pin(rxd_pin),
    .o_tx_busy(tx_busy), .o_rx_active(rx_act));
  irc_xcvr_model irc_xcvr_model_inst (.i_clk_sys(clk), .i_fire(fire), .o_rxd_pin(rxd_pin));
  always #5 clk = ~clk;
  // Pulse starts on the pin, sampled where settled
  always @(negedge clk) begin
    cyc <= cyc + 1;
    txd_q <= txd_pin;
    if (txd_pin === 1'b1 && txd_q === 1'b0) begin
      if (n_rise == 0) first_r <= cyc;
      last_r <= cyc;
      n_rise <= n_rise + 1;
    end
  end
  task automatic tick(int n); repeat (n) @(negedge clk); endtask
  task automatic pulse(); fire = 1; tick(1); fire = 0; endtask
  task automatic low_span(output int span);
    int w;
    span = 0;
    for (w = 0; w < 100 && rxd === 1'b1; w++) tick(1);
    while (rxd === 1'b0 && span < 100) begin span++; tick(1); end
  endtask
  task automatic t_bypass();
    en = 0; txd = 0; pulse();
    `CHK("byp_txd", 1'b0, txd_pin)
    `CHK("byp_ready", 1'b0, tx_ready)
    txd = 1; tick(1);
    `CHK("byp_rxd", 1'b0, rxd)
    `CHK("byp_txd1", 1'b1, txd_pin)
    tick(4); $display("t_bypass done");
  endtask
  task automatic t_tx();
    int n, w;
    en = 1; tick(2); n_rise = 0;
    `CHK("tx_ready", 1'b1, tx_ready)
    tx_valid = 1;
    for (n = 0; n < 20 && tx_ready; n++) begin txd = (n == 1); tick(1); end
    tx_valid = 0;
    `CHK("refused", 1'b0, tx_ready)
    `CHK("fifo_words", 8, n)
    for (w = 0; w < 600 && (tx_busy !== 1'b0 || n_rise < 1); w++) tick(1);
    `CHK("tx_idle", 1'b0, tx_busy)
    tick(4);
    `CHK("zero_pulses", n - 1, n_rise)
    `CHK("bit_spacing", 16 * (n - 1), last_r - first_r)
    $display("t_tx done");
  endtask
  task automatic t_rx(int gap, int exp_low);
    int sp;
    tick(40);
    fork
      begin pulse(); tick(gap - 1); pulse(); end
      low_span(sp);
    join
    `CHK("rx_low", exp_low, sp)
    `CHK("rx_done", 1'b0, rx_act)
    $display("t_rx done");
  endtask
  task automatic t_half();
    int w, sp;
    tick(40); txd = 0; tx_valid = 1; tick(1); tx_valid = 0;
    for (w = 0; w < 40 && tx_busy !== 1'b1; w++) tick(1);
    fork pulse(); low_span(sp); join
    `CHK("half_duplex", 0, sp)
    `CHK("half_rx_idle", 1'b0, rx_act)
    $display("t_half done");
  endtask
  task automatic t_div();
    int w;
    baud_div = 16'h0002;
    tick(2);
    n_rise = 0;
    txd = 0;
    tx_valid = 1;
    tick(2);
    tx_valid = 0;
    for (w = 0; w < 300 && (tx_busy !== 1'b0 || n_rise < 2); w++) tick(1);
    tick(4);
    `CHK("div_pulses", 2, n_rise)
    `CHK("div_spacing", 32, last_r - first_r)
    baud_div = 16'h0001;
    $display("t_div done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    clk = 0; rst = 1; en = 0; txd = 1; tx_valid = 0; fire = 0;
    baud_div = 16'h0001;
    tick(3); rst = 0; tick(1);
    `CHK("rst_busy", 1'b0, tx_busy)
    t_bypass();
    t_tx();
    t_rx(16, 32);
    t_rx(6, 16);
    t_half();
    t_div();
    tally_and_finish();
  end
  initial begin
    #100000;
    num_errors++;
    tally_and_finish();
  end
endmodule // tb_infrared_pulse_codec
